// file: hw/hbm_pkg.sv
// Constants, types and helpers for the host bus byte lane mapper
package hbm_pkg;
  // ==========================================================
  // Widths and offsets
  localparam int ADDR_W = 6;
  localparam int DATA_W = 16;
  localparam int BYTE_W = 8;
  localparam int REG_COUNT = 32;
  localparam int LANE_LO_LSB = 0;
  localparam int LANE_HI_LSB = 8;
  localparam logic [5:0] OFS_DATA_PORT = 6'h10;
  localparam logic [5:0] OFS_UNUSED = 6'h11;
  localparam logic [5:0] OFS_LOW_ONLY = 6'h1e;
  localparam logic [5:0] OFS_RESET = 6'h1f;
  // ==========================================================
  // Reset and fill values
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] FILL_BYTE = 8'h00;
  localparam logic [15:0] DATA_RESET = 16'h0000;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    HBM_MODE_NONE,
    HBM_MODE_ISA,
    HBM_MODE_186
  } hbm_mode_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [5:0] addr;
    logic [15:0] wdata;
  } hbm_req_t;

  // ==========================================================
  // Helpers
  function automatic logic [5:0] hbm_pair(input logic [5:0] a, input logic odd);
    hbm_pair = {a[5:1], odd};
  endfunction : hbm_pair

  function automatic logic [7:0] hbm_lane(input logic [15:0] d, input logic hi);
    hbm_lane = hi ? d[LANE_HI_LSB +: BYTE_W] : d[LANE_LO_LSB +: BYTE_W];
  endfunction : hbm_lane
endpackage : hbm_pkg

// file: hw/hbm_host_bus_byte_lane_mapper.sv
// Host bus decoder and byte lane router with its register bytes
`timescale 1ns/1ps
`default_nettype none
module hbm_host_bus_byte_lane_mapper (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RESET,
  // Bus mode straps
  input wire logic EEPROM_SELECT_STRAP_PIN,
  input wire logic EEPROM_CLOCK_STRAP_PIN,
  // Host bus
  input wire logic [5:0] HOST_ADDR,
  input wire logic ADDRESS_ENABLE_PROGRAM_STROBE,
  input wire logic HOST_READ_STROBE_N,
  input wire logic HOST_WRITE_STROBE_N,
  input wire logic [15:0] HOST_DATA_LANES_IN,
  output logic [15:0] HOST_DATA_LANES_OUT,
  output logic HOST_DATA_LANES_OE_N,
  // Packet data port
  input wire logic [15:0] PKT_RD_DATA,
  output logic PKT_RD_STROBE,
  output logic PKT_WR_STROBE,
  output logic [15:0] PKT_WR_DATA,
  // Register write report and soft reset
  output logic REG_WR_STROBE,
  output logic [5:0] REG_WR_OFFSET,
  output logic [7:0] REG_WR_BYTE,
  output logic CORE_RESET_PULSE,
  // Mode status
  output logic BUS_MODE_VALID,
  output logic BUS_MODE_186
);

  // ==========================================================
  // State
  hbm_pkg::hbm_mode_t mode_ff;
  hbm_pkg::hbm_mode_t nxt_mode;
  logic strap_done_ff;
  logic mode_ok_ff;
  logic mode_186_ff;
  logic rd_prev_ff;
  logic wr_prev_ff;
  logic [7:0] regs_ff [0:hbm_pkg::REG_COUNT-1];
  logic [15:0] dout_ff;
  logic oe_n_ff;
  logic pkt_rd_ff;
  logic pkt_wr_ff;
  logic [15:0] pkt_wdata_ff;
  logic reg_wr_ff;
  logic [5:0] reg_ofs_ff;
  logic [7:0] reg_byte_ff;
  logic core_rst_ff;

  // ==========================================================
  // Request decode
  hbm_pkg::hbm_req_t req;
  assign req.rd = ~HOST_READ_STROBE_N;
  assign req.wr = ~HOST_WRITE_STROBE_N;
  assign req.addr = HOST_ADDR;
  assign req.wdata = HOST_DATA_LANES_IN;

  wire is_isa = (mode_ff == hbm_pkg::HBM_MODE_ISA);
  wire is_186 = (mode_ff == hbm_pkg::HBM_MODE_186);
  // ISA cycles are only ours while address enable is low
  wire sel = strap_done_ff & (is_186 | (is_isa & ~ADDRESS_ENABLE_PROGRAM_STROBE));
  wire rd_act = sel & req.rd;
  wire rd_go = rd_act & ~rd_prev_ff;
  wire wr_go = sel & req.wr & ~wr_prev_ff;

  wire is_odd = req.addr[0];
  wire at_dp = (req.addr == hbm_pkg::OFS_DATA_PORT);
  wire at_unused = (req.addr == hbm_pkg::OFS_UNUSED);
  wire at_low_only = (req.addr == hbm_pkg::OFS_LOW_ONLY);
  wire at_reset = (req.addr == hbm_pkg::OFS_RESET);
  wire [5:0] even_ofs = hbm_pkg::hbm_pair(req.addr, 1'b0);
  wire [5:0] odd_ofs = hbm_pkg::hbm_pair(req.addr, 1'b1);
  wire [7:0] even_byte = regs_ff[even_ofs[4:0]];
  wire [7:0] odd_byte = regs_ff[odd_ofs[4:0]];

  // ==========================================================
  // Strap decode
  always_comb begin
    nxt_mode = hbm_pkg::HBM_MODE_NONE;
    if (!EEPROM_SELECT_STRAP_PIN && !EEPROM_CLOCK_STRAP_PIN) begin
      nxt_mode = hbm_pkg::HBM_MODE_ISA;
    end else if (!EEPROM_SELECT_STRAP_PIN && EEPROM_CLOCK_STRAP_PIN) begin
      nxt_mode = hbm_pkg::HBM_MODE_186;
    end
  end

  // Straps caught on the first edge after reset release
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      mode_ff <= hbm_pkg::HBM_MODE_NONE;
      strap_done_ff <= 1'b0;
      mode_ok_ff <= 1'b0;
      mode_186_ff <= 1'b0;
    end else if (!strap_done_ff) begin
      mode_ff <= nxt_mode;
      strap_done_ff <= 1'b1;
      mode_ok_ff <= (nxt_mode != hbm_pkg::HBM_MODE_NONE);
      mode_186_ff <= (nxt_mode == hbm_pkg::HBM_MODE_186);
    end
  end

  // ==========================================================
  // Read lane routing
  // ISA odd mirrors the odd byte, 186 odd keeps the even byte low
  wire [7:0] rd_lo = (is_odd && is_isa) ? odd_byte : even_byte;
  wire [7:0] rd_hi = at_low_only ? hbm_pkg::FILL_BYTE : odd_byte;
  wire [15:0] rd_word = at_dp ? PKT_RD_DATA :
                        (at_reset | at_unused) ? {hbm_pkg::FILL_BYTE, hbm_pkg::FILL_BYTE} :
                        at_low_only ? {rd_hi, even_byte} :
                        {rd_hi, rd_lo};

  // ==========================================================
  // Write lane routing
  wire wr_hi_lane = is_186 & is_odd;
  wire [7:0] wr_byte = hbm_pkg::hbm_lane(req.wdata, wr_hi_lane);
  wire wr_reg = wr_go & ~at_dp & ~at_unused;
  wire wr_pkt = wr_go & at_dp;

  // ==========================================================
  // Strobe edge tracking
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      rd_prev_ff <= 1'b0;
      wr_prev_ff <= 1'b0;
    end else begin
      rd_prev_ff <= rd_act;
      wr_prev_ff <= sel & req.wr;
    end
  end

  // ==========================================================
  // Register bytes
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      for (int i = 0; i < hbm_pkg::REG_COUNT; i++) begin
        regs_ff[i] <= hbm_pkg::REG_RESET;
      end
    end else if (wr_reg) begin
      regs_ff[req.addr[4:0]] <= wr_byte;
    end
  end

  // ==========================================================
  // Read data driver
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      dout_ff <= hbm_pkg::DATA_RESET;
      oe_n_ff <= 1'b1;
    end else begin
      dout_ff <= rd_act ? rd_word : hbm_pkg::DATA_RESET;
      oe_n_ff <= ~rd_act;
    end
  end

  // ==========================================================
  // Side effects, one pulse per access
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      pkt_rd_ff <= 1'b0;
      pkt_wr_ff <= 1'b0;
      pkt_wdata_ff <= hbm_pkg::DATA_RESET;
      reg_wr_ff <= 1'b0;
      reg_ofs_ff <= 6'h00;
      reg_byte_ff <= hbm_pkg::REG_RESET;
      core_rst_ff <= 1'b0;
    end else begin
      pkt_rd_ff <= rd_go & at_dp;
      pkt_wr_ff <= wr_pkt;
      if (wr_pkt) begin
        pkt_wdata_ff <= req.wdata;
      end
      reg_wr_ff <= wr_reg;
      if (wr_reg) begin
        reg_ofs_ff <= req.addr;
        reg_byte_ff <= wr_byte;
      end
      core_rst_ff <= rd_go & at_reset;
    end
  end

  assign HOST_DATA_LANES_OUT = dout_ff;
  assign HOST_DATA_LANES_OE_N = oe_n_ff;
  assign PKT_RD_STROBE = pkt_rd_ff;
  assign PKT_WR_STROBE = pkt_wr_ff;
  assign PKT_WR_DATA = pkt_wdata_ff;
  assign REG_WR_STROBE = reg_wr_ff;
  assign REG_WR_OFFSET = reg_ofs_ff;
  assign REG_WR_BYTE = reg_byte_ff;
  assign CORE_RESET_PULSE = core_rst_ff;
  assign BUS_MODE_VALID = mode_ok_ff;
  assign BUS_MODE_186 = mode_186_ff;

  // ==========================================================
  // Checks
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (RESET);

  wire plain_rd = rd_act & ~at_dp & ~at_unused & ~at_low_only & ~at_reset;

  sequence s_rst_rd;
    rd_go & at_reset;
  endsequence
  sequence s_one_pulse;
    CORE_RESET_PULSE ##1 !CORE_RESET_PULSE;
  endsequence
  sequence s_dp_rd_held;
    (rd_go && at_dp) ##1 (rd_act && at_dp);
  endsequence
  sequence s_rd_end;
    rd_act ##1 !rd_act;
  endsequence

  // ==========================================================
  // Strap capture and bus selection
  a_strap_isa: assert property ($rose(strap_done_ff) && !$past(EEPROM_SELECT_STRAP_PIN)
    && !$past(EEPROM_CLOCK_STRAP_PIN) |-> is_isa)
    else $error("ISA strap not decoded");
  a_strap_186: assert property ($rose(strap_done_ff) && !$past(EEPROM_SELECT_STRAP_PIN)
    && $past(EEPROM_CLOCK_STRAP_PIN) |-> is_186)
    else $error("186 strap not decoded");
  a_mode_status: assert property ($rose(strap_done_ff) |->
    BUS_MODE_VALID == !$past(EEPROM_SELECT_STRAP_PIN)
    && BUS_MODE_186 == (!$past(EEPROM_SELECT_STRAP_PIN) && $past(EEPROM_CLOCK_STRAP_PIN)))
    else $error("Mode status outputs wrong");
  a_strap_hold: assert property (strap_done_ff |=> $stable(mode_ff) && $stable(BUS_MODE_186))
    else $error("Bus mode changed after capture");
  a_no_mode_quiet: assert property (!BUS_MODE_VALID |=> HOST_DATA_LANES_OE_N
    && !REG_WR_STROBE && !PKT_WR_STROBE)
    else $error("Bus answered without a mode");
  a_isa_aen_off: assert property (is_isa && ADDRESS_ENABLE_PROGRAM_STROBE
    |=> HOST_DATA_LANES_OE_N && !REG_WR_STROBE && !PKT_WR_STROBE && !CORE_RESET_PULSE)
    else $error("ISA cycle taken with address enable high");
  a_186_aen_free: assert property (is_186 && ADDRESS_ENABLE_PROGRAM_STROBE && req.rd
    |=> !HOST_DATA_LANES_OE_N)
    else $error("186 read refused by address enable");

  // ==========================================================
  // Read lanes
  a_isa_even_rd: assert property (plain_rd && is_isa && !is_odd
    |=> HOST_DATA_LANES_OUT == {$past(odd_byte), $past(even_byte)} && !HOST_DATA_LANES_OE_N)
    else $error("ISA even read lanes wrong");
  a_isa_odd_rd: assert property (plain_rd && is_isa && is_odd
    |=> HOST_DATA_LANES_OUT == {2{$past(odd_byte)}})
    else $error("ISA odd read lanes wrong");
  a_186_even_rd: assert property (plain_rd && is_186 && !is_odd
    |=> HOST_DATA_LANES_OUT == {$past(odd_byte), $past(even_byte)})
    else $error("186 even read lanes wrong");
  a_186_odd_rd: assert property (plain_rd && is_186 && is_odd
    |=> HOST_DATA_LANES_OUT == {$past(odd_byte), $past(even_byte)})
    else $error("186 odd read lanes wrong");
  a_pkt_rd: assert property (rd_go && at_dp
    |=> PKT_RD_STROBE && HOST_DATA_LANES_OUT == $past(PKT_RD_DATA))
    else $error("Data port read not routed");
  a_pkt_rd_once: assert property (s_dp_rd_held |=> !PKT_RD_STROBE)
    else $error("Data port read strobe repeated");
  a_low_only_rd: assert property (rd_act && at_low_only
    |=> HOST_DATA_LANES_OUT[7:0] == $past(even_byte))
    else $error("Offset 1E read low lane wrong");
  a_low_only_hi: assert property (rd_act && at_low_only
    |=> HOST_DATA_LANES_OUT[15:8] == hbm_pkg::FILL_BYTE)
    else $error("Offset 1E read high lane not filled");
  a_fill_rd: assert property (rd_act && (at_reset || at_unused)
    |=> HOST_DATA_LANES_OUT == {hbm_pkg::FILL_BYTE, hbm_pkg::FILL_BYTE})
    else $error("Reset or unused read not filled");
  a_rd_release: assert property (s_rd_end |=> HOST_DATA_LANES_OE_N
    && HOST_DATA_LANES_OUT == hbm_pkg::DATA_RESET)
    else $error("Read lanes not released");
  a_rst_trigger: assert property (s_rst_rd |=> s_one_pulse)
    else $error("Reset trigger not one pulse");

  // ==========================================================
  // Write lanes
  a_isa_wr_lane: assert property (wr_reg && is_isa
    |=> REG_WR_STROBE && REG_WR_BYTE == $past(HOST_DATA_LANES_IN[7:0]))
    else $error("ISA write lane wrong");
  a_186_odd_wr: assert property (wr_reg && is_186 && is_odd
    |=> REG_WR_BYTE == $past(HOST_DATA_LANES_IN[15:8]))
    else $error("186 odd write lane wrong");
  a_186_even_wr: assert property (wr_reg && is_186 && !is_odd
    |=> REG_WR_BYTE == $past(HOST_DATA_LANES_IN[7:0]))
    else $error("186 even write lane wrong");
  a_reg_store: assert property (REG_WR_STROBE
    |-> regs_ff[REG_WR_OFFSET[4:0]] == REG_WR_BYTE)
    else $error("Register byte not stored");
  a_dp_write: assert property (wr_go && at_dp
    |=> PKT_WR_STROBE && !REG_WR_STROBE && PKT_WR_DATA == $past(HOST_DATA_LANES_IN))
    else $error("Data port write not routed");
  a_isa_rst_wr: assert property (wr_go && is_isa && at_reset
    |=> REG_WR_OFFSET == hbm_pkg::OFS_RESET && !CORE_RESET_PULSE
    && REG_WR_BYTE == $past(HOST_DATA_LANES_IN[7:0]))
    else $error("ISA 1F write wrong");
  a_186_rst_wr: assert property (wr_go && is_186 && at_reset
    |=> REG_WR_BYTE == $past(HOST_DATA_LANES_IN[15:8]))
    else $error("186 1F write wrong");
  a_unused_wr: assert property (wr_go && at_unused
    |=> !REG_WR_STROBE && !PKT_WR_STROBE)
    else $error("Write at 11h not ignored");
endmodule : hbm_host_bus_byte_lane_mapper
`default_nettype wire

// file: dv/hbm_host_model.sv
// Host bus master model for the mapper's register bus
`timescale 1ns/1ps
`default_nettype none
module hbm_host_model (
  // Clock
  input wire logic clk,
  // Bus request and answer
  output var hbm_pkg::hbm_req_t req,
  input wire logic [15:0] rdata,
  input wire logic oe_n
);
  initial req = '0;
  // ==========================================================
  // Write: one sampled low cycle, lanes scrambled on release
  task automatic write(input logic [5:0] a, input logic [15:0] d);
    @(posedge clk);
    req.wr <= 1'b1;
    req.addr <= a;
    req.wdata <= d;
    @(posedge clk);
    req.wr <= 1'b0;
    req.wdata <= ~d;
  endtask : write
  // ==========================================================
  // Read: strobe held two sampled cycles, answer taken after the first
  task automatic read(input logic [5:0] a, output logic [15:0] q, output logic oe);
    @(posedge clk);
    req.rd <= 1'b1;
    req.addr <= a;
    @(posedge clk);
    #1;
    q = rdata;
    oe = oe_n;
    @(posedge clk);
    req.rd <= 1'b0;
  endtask : read
endmodule : hbm_host_model
`default_nettype wire

// file: dv/hbm_host_bus_byte_lane_mapper_bench.sv
// Self-checking bench for the host bus byte lane mapper
`timescale 1ns/1ps
`default_nettype none
module hbm_host_bus_byte_lane_mapper_bench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic s_sel = 1'b0;
  logic s_clk = 1'b0;
  logic aen = 1'b0;
  logic [15:0] pkt = 16'h5aa5;
  hbm_pkg::hbm_req_t req;
  logic [15:0] dout, pkt_wd;
  logic oe_n, pkt_rd, pkt_wr, reg_wr, core_rst, mode_ok, mode_186;
  logic [5:0] wr_ofs;
  logic [7:0] wr_byte;
  logic [7:0] shadow [32];
  int num_errors = 0;
  int n_checks = 0;
  int n_core = 0;
  int n_pkt = 0;
  initial begin
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    if (core_rst === 1'b1) n_core++;
    if (pkt_rd === 1'b1) n_pkt++;
  end
  hbm_host_bus_byte_lane_mapper hbm_host_bus_byte_lane_mapper_inst (
    .SYS_CLK(clk), .RESET(rst),
    .EEPROM_SELECT_STRAP_PIN(s_sel), .EEPROM_CLOCK_STRAP_PIN(s_clk),
    .HOST_ADDR(req.addr), .ADDRESS_ENABLE_PROGRAM_STROBE(aen),
    .HOST_READ_STROBE_N(~req.rd), .HOST_WRITE_STROBE_N(~req.wr),
    .HOST_DATA_LANES_IN(req.wdata), .HOST_DATA_LANES_OUT(dout), .HOST_DATA_LANES_OE_N(oe_n),
    .PKT_RD_DATA(pkt), .PKT_RD_STROBE(pkt_rd), .PKT_WR_STROBE(pkt_wr), .PKT_WR_DATA(pkt_wd),
    .REG_WR_STROBE(reg_wr), .REG_WR_OFFSET(wr_ofs), .REG_WR_BYTE(wr_byte),
    .CORE_RESET_PULSE(core_rst), .BUS_MODE_VALID(mode_ok), .BUS_MODE_186(mode_186)
  );
  hbm_host_model hbm_host_model_inst (.clk(clk), .req(req), .rdata(dout), .oe_n(oe_n));
  // ==========================================================
  // Shared tasks
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : conclude
  // Reset with given straps; address enable high in 186 mode must not matter
  task automatic start(input logic sel, input logic ck);
    @(posedge clk);
    rst <= 1'b1;
    s_sel <= sel;
    s_clk <= ck;
    aen <= ck;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    n_core = 0;
    n_pkt = 0;
    check("mode valid", 16'(!sel), 16'(mode_ok));
    check("mode 186", 16'(!sel && ck), 16'(mode_186));
  endtask : start
  // ==========================================================
  // Write every offset, then read every offset back
  task automatic lanes(input logic m);
    logic [15:0] q, e, d;
    logic oe;
    logic [7:0] v;
    logic [5:0] p;
    start(1'b0, m);
    hbm_host_model_inst.read(6'h03, q, oe);
    check("reset bytes", 16'h0000, q);
    for (int a = 0; a < 32; a++) begin
      p = 6'(a);
      v = 8'(a * 7 + 8'h31);
      d = (m & p[0]) ? {v, ~v} : {~v, v};
      shadow[a] = v;
      hbm_host_model_inst.write(p, d);
      #1;
      if (a == 16) begin
        check("pkt wr strobe", 16'h0001, 16'(pkt_wr));
        check("pkt wr data", d, pkt_wd);
      end else if (a == 17) begin
        check("unused wr", 16'h0000, 16'(reg_wr));
      end else begin
        check("wr strobe", 16'h0001, 16'(reg_wr));
        check("wr offset", 16'(p), 16'(wr_ofs));
        check("wr byte", 16'(v), 16'(wr_byte));
      end
    end
    for (int a = 0; a < 32; a++) begin
      p = 6'(a);
      e = {shadow[p | 6'h01], (p[0] & ~m) ? shadow[p | 6'h01] : shadow[p & 6'h3e]};
      if (a == 16) e = pkt;
      if (a == 17 || a == 31) e = 16'h0000;
      if (a == 30) e[15:8] = 8'h00;
      hbm_host_model_inst.read(p, q, oe);
      check("rd oe_n", 16'h0000, 16'(oe));
      check("rd lanes", e, q);
    end
    #1;
    check("core pulses", 16'h0001, 16'(n_core));
    check("pkt rd pulses", 16'h0001, 16'(n_pkt));
    $display("lanes mode %0d done", m);
  endtask : lanes
  // ==========================================================
  // Straps without a mode and ISA cycles not addressed to us
  task automatic refused();
    logic [15:0] q;
    logic oe;
    start(1'b1, 1'b0);
    hbm_host_model_inst.read(6'h00, q, oe);
    check("none oe_n", 16'h0001, 16'(oe));
    hbm_host_model_inst.write(6'h00, 16'h00ff);
    #1;
    check("none wr", 16'h0000, 16'(reg_wr));
    start(1'b0, 1'b0);
    @(posedge clk) aen <= 1'b1;
    hbm_host_model_inst.read(6'h00, q, oe);
    check("aen oe_n", 16'h0001, 16'(oe));
    $display("refused done");
  endtask : refused
  initial begin
    lanes(1'b0);
    lanes(1'b1);
    refused();
    conclude();
  end
  initial begin
    #2000000;
    num_errors++;
    conclude();
  end
endmodule : hbm_host_bus_byte_lane_mapper_bench
`default_nettype wire
